// file: rtl/pfcfg_regs.vh
// Register indices, field positions, reset values and timing counts of the per-setup filter block
`ifndef PFCFG_REGS_VH
`define PFCFG_REGS_VH

// Register-select codes; byte address is four times the code
`define PFCFG_IDX_SETUP_FIRST 6'h21
`define PFCFG_IDX_SETUP_LAST 6'h28
`define PFCFG_IDX_POWER_CTRL 6'h30
`define PFCFG_IDX_STATUS 6'h31

// Filter register layout
`define PFCFG_FILT_W 24
`define PFCFG_FILT_RESET 24'h060180
`define PFCFG_FILT_RW_MASK 24'hFF07FF
`define PFCFG_TYPE_HI 23
`define PFCFG_TYPE_LO 21
`define PFCFG_NOTCH60_BIT 20
`define PFCFG_POST_HI 19
`define PFCFG_POST_LO 17
`define PFCFG_SINGLE_BIT 16
`define PFCFG_RATE_HI 10
`define PFCFG_RATE_LO 0

// Filter type codes
`define PFCFG_TYPE_SINC4 3'h0
`define PFCFG_TYPE_SINC3 3'h2
`define PFCFG_TYPE_FAST4 3'h4
`define PFCFG_TYPE_FAST3 3'h5

// Power modes
`define PFCFG_PWR_LOW 2'h0
`define PFCFG_PWR_MID 2'h1
`define PFCFG_PWR_FULL 2'h2
`define PFCFG_PWR_RESET 2'h2

// Averaging depths and their shifts
`define PFCFG_AVG_FULL 5'h10
`define PFCFG_AVG_LOW 5'h08
`define PFCFG_AVG_SH_FULL 3'h4
`define PFCFG_AVG_SH_LOW 3'h3

// Settling in conversion periods
`define PFCFG_SETTLE_FAST 3'h1
`define PFCFG_SETTLE_SINC3 3'h3
`define PFCFG_SETTLE_SINC4 3'h4

`endif

// file: rtl/pfcfg_word.v
// One filter configuration word with masked write and fixed reset value
`timescale 1ns/1ps
`default_nettype none
`include "pfcfg_regs.vh"

module pfcfg_word #(
    parameter [23:0] RESET_VAL = `PFCFG_FILT_RESET,
    parameter [23:0] RW_MASK = `PFCFG_FILT_RW_MASK
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write side
    input wire wr_en,
    input wire [23:0] wr_data,
    // Stored word
    output reg [23:0] word_r
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_r <= RESET_VAL;
        end else if (wr_en) begin
            word_r <= wr_data & RW_MASK;
        end
    end

endmodule // pfcfg_word

`default_nettype wire

// file: rtl/pfcfg_top.v
// Per-setup filter configuration registers with conversion-time decode and averaging stage
//
// Behaviour
// - Eight filter configuration words exist, word n serving setup n, each written on its own.
// - The words sit at register-select codes 0x21 through 0x28 in setup order.
// - Reset loads every word with 0x060180.
// - Type bits 23:21 decode 000 sinc4, 010 sinc3, 100 fast sinc4, 101 fast sinc3, others reserved.
// - Fast-settling types average 16 sinc results in full or mid power and 8 in low power.
// - Fast-settling types give a settled result after one conversion period.
// - Each word holds an 11-bit rate code in bits 10:0 and bits 15:11 read zero.
// - Bit 20 enables the extra 60 Hz notch for a 50 Hz first notch.
// - Bits 19:17 select the post filter following the sinc3 stage.
`timescale 1ns/1ps
`default_nettype none
`include "pfcfg_regs.vh"

module pfcfg_top #(
    parameter NUM_SETUPS = 8,
    parameter DATA_W = 24
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Conversion request from the sequencer
    input wire conv_req,
    input wire [2:0] conv_setup,
    // Sinc results from the modulator path
    input wire sinc_valid,
    input wire [DATA_W-1:0] sinc_data,
    // Settings of the running conversion
    output reg conv_active,
    output reg [2:0] filter_type,
    output reg type_reserved,
    output reg fast_settle,
    output reg sixty_hz_notch_enable,
    output reg [2:0] post_filter_sel,
    output reg single_cycle,
    output reg [10:0] rate_divider_code,
    output reg [4:0] avg_depth,
    output reg [2:0] settle_periods,
    // Filtered result
    output reg result_valid,
    output reg [DATA_W-1:0] result_data
);

    wire [23:0] filt_word [0:NUM_SETUPS-1];
    wire [5:0] word_idx;
    wire [5:0] setup_off;
    wire setup_hit;
    wire power_hit;
    wire status_hit;
    wire mapped;
    wire setup_phase;
    wire access_done;
    wire [2:0] wr_setup;
    wire [23:0] sel_word;
    wire [2:0] sel_type;
    reg sel_fast;
    reg sel_reserved;
    reg [2:0] settle_nxt;
    reg [1:0] power_mode_r;
    reg last_reserved_r;
    reg [2:0] last_setup_r;
    reg [31:0] rd_nxt;
    reg [4:0] depth_nxt;
    reg [2:0] shift_r;
    reg [2:0] shift_nxt;
    reg [DATA_W+3:0] acc_r;
    reg [4:0] cnt_r;
    wire [DATA_W+3:0] sinc_ext;
    wire [DATA_W+3:0] acc_sum;
    wire [DATA_W+3:0] acc_shifted;
    wire [NUM_SETUPS-1:0] wr_hit;

    // Bus answer tracker; an access phase is answered only after its own setup
    localparam [1:0] BUS_IDLE = 2'b01;
    localparam [1:0] BUS_ANSWER = 2'b10;
    reg [1:0] bus_state_r;
    reg [1:0] bus_state_nxt;

    // Averaging stage mode, fixed for the whole conversion
    localparam [2:0] AVG_HOLD = 3'b001;
    localparam [2:0] AVG_PASS = 3'b010;
    localparam [2:0] AVG_SUM = 3'b100;
    reg [2:0] avg_state_r;
    reg [2:0] avg_state_nxt;

    // Register decode; codes are word indices, so the byte address is code times four
    assign word_idx = paddr[7:2];
    assign setup_off = word_idx - `PFCFG_IDX_SETUP_FIRST;
    assign setup_hit = (word_idx >= `PFCFG_IDX_SETUP_FIRST) &&
                       (word_idx <= `PFCFG_IDX_SETUP_LAST);
    assign power_hit = (word_idx == `PFCFG_IDX_POWER_CTRL);
    assign status_hit = (word_idx == `PFCFG_IDX_STATUS);
    assign mapped = setup_hit || power_hit || status_hit;
    assign wr_setup = setup_off[2:0];
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && (bus_state_r == BUS_ANSWER);

    // Answer tracker; pready follows it at the same edge
    always @* begin
        case (bus_state_r)
            BUS_IDLE: begin
                bus_state_nxt = setup_phase ? BUS_ANSWER : BUS_IDLE;
            end
            BUS_ANSWER: begin
                // A setup may follow an access at once
                bus_state_nxt = setup_phase ? BUS_ANSWER : BUS_IDLE;
            end
            default: begin
                bus_state_nxt = BUS_IDLE;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_r <= BUS_IDLE;
        end else begin
            bus_state_r <= bus_state_nxt;
        end
    end

    // Eight independent words
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SETUPS; gi = gi + 1) begin : g_setup
            assign wr_hit[gi] = access_done && pwrite && setup_hit && (wr_setup == gi);
            pfcfg_word #(
                .RESET_VAL(`PFCFG_FILT_RESET),
                .RW_MASK(`PFCFG_FILT_RW_MASK)
            ) u_word (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(wr_hit[gi]),
                .wr_data(pwdata[23:0]),
                .word_r(filt_word[gi])
            );
        end
    endgenerate

    // Read data is staged in the setup cycle so prdata comes from a flop
    always @* begin
        case ({setup_hit, power_hit, status_hit})
            3'b100: begin
                rd_nxt = {8'h00, filt_word[wr_setup]};
            end
            3'b010: begin
                rd_nxt = {30'h00000000, power_mode_r};
            end
            3'b001: begin
                rd_nxt = {27'h0000000, last_reserved_r, conv_active, last_setup_r};
            end
            default: begin
                // Unmapped index reads zero
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (bus_state_nxt == BUS_ANSWER) begin
            prdata <= pwrite ? 32'h00000000 : rd_nxt;
            pready <= 1'b1;
            pslverr <= !mapped;
        end else begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Power mode steers the averaging depth
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_mode_r <= `PFCFG_PWR_RESET;
        end else if (access_done && pwrite && power_hit) begin
            power_mode_r <= pwdata[1:0];
        end
    end

    // Settings captured at conversion start; later writes wait for the next one
    assign sel_word = filt_word[conv_setup];
    assign sel_type = sel_word[`PFCFG_TYPE_HI:`PFCFG_TYPE_LO];

    // Type decode; reserved codes get no averaging and no results
    always @* begin
        sel_fast = 1'b0;
        sel_reserved = 1'b0;
        settle_nxt = `PFCFG_SETTLE_SINC4;
        case (sel_type)
            `PFCFG_TYPE_SINC4: begin
                settle_nxt = `PFCFG_SETTLE_SINC4;
            end
            `PFCFG_TYPE_SINC3: begin
                settle_nxt = `PFCFG_SETTLE_SINC3;
            end
            `PFCFG_TYPE_FAST4: begin
                sel_fast = 1'b1;
                settle_nxt = `PFCFG_SETTLE_FAST;
            end
            `PFCFG_TYPE_FAST3: begin
                sel_fast = 1'b1;
                settle_nxt = `PFCFG_SETTLE_FAST;
            end
            default: begin
                sel_reserved = 1'b1;
            end
        endcase
        // Single-cycle mode also settles sinc4 and sinc3 in one period
        if (sel_word[`PFCFG_SINGLE_BIT]) begin
            settle_nxt = `PFCFG_SETTLE_FAST;
        end
    end

    always @* begin
        case (power_mode_r)
            `PFCFG_PWR_LOW: begin
                depth_nxt = `PFCFG_AVG_LOW;
                shift_nxt = `PFCFG_AVG_SH_LOW;
            end
            `PFCFG_PWR_MID: begin
                depth_nxt = `PFCFG_AVG_FULL;
                shift_nxt = `PFCFG_AVG_SH_FULL;
            end
            default: begin
                // Full power, and the unused code 3 behaves as full
                depth_nxt = `PFCFG_AVG_FULL;
                shift_nxt = `PFCFG_AVG_SH_FULL;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_active <= 1'b0;
            filter_type <= `PFCFG_TYPE_SINC4;
            type_reserved <= 1'b0;
            fast_settle <= 1'b0;
            sixty_hz_notch_enable <= 1'b0;
            post_filter_sel <= 3'h0;
            single_cycle <= 1'b0;
            rate_divider_code <= 11'h000;
            avg_depth <= 5'h00;
            shift_r <= 3'h0;
            settle_periods <= 3'h0;
            last_setup_r <= 3'h0;
            last_reserved_r <= 1'b0;
        end else if (conv_req) begin
            conv_active <= 1'b1;
            filter_type <= sel_type;
            type_reserved <= sel_reserved;
            fast_settle <= sel_fast;
            sixty_hz_notch_enable <= sel_word[`PFCFG_NOTCH60_BIT];
            post_filter_sel <= sel_word[`PFCFG_POST_HI:`PFCFG_POST_LO];
            single_cycle <= sel_word[`PFCFG_SINGLE_BIT];
            rate_divider_code <= sel_word[`PFCFG_RATE_HI:`PFCFG_RATE_LO];
            avg_depth <= sel_fast ? depth_nxt : 5'h01;
            shift_r <= sel_fast ? shift_nxt : 3'h0;
            last_setup_r <= conv_setup;
            last_reserved_r <= sel_reserved;
            settle_periods <= settle_nxt;
        end
    end

    // Stage mode chosen at conversion start, so a later write cannot switch it
    always @* begin
        avg_state_nxt = avg_state_r;
        if (conv_req) begin
            if (sel_reserved) begin
                avg_state_nxt = AVG_HOLD;
            end else if (sel_fast) begin
                avg_state_nxt = AVG_SUM;
            end else begin
                avg_state_nxt = AVG_PASS;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            avg_state_r <= AVG_HOLD;
        end else begin
            avg_state_r <= avg_state_nxt;
        end
    end

    // Averaging stage; guard bits keep the sum of 16 from overflowing
    assign sinc_ext = {{4{sinc_data[DATA_W-1]}}, sinc_data};
    assign acc_sum = acc_r + sinc_ext;
    assign acc_shifted = $signed(acc_sum) >>> shift_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= {(DATA_W+4){1'b0}};
            cnt_r <= 5'h00;
            result_valid <= 1'b0;
            result_data <= {DATA_W{1'b0}};
        end else begin
            result_valid <= 1'b0;
            if (conv_req) begin
                // New conversion discards any partial average
                acc_r <= {(DATA_W+4){1'b0}};
                cnt_r <= 5'h00;
            end else if (sinc_valid) begin
                case (avg_state_r)
                    AVG_PASS: begin
                        result_valid <= 1'b1;
                        result_data <= sinc_data;
                    end
                    AVG_SUM: begin
                        if (cnt_r == avg_depth - 5'h01) begin
                            // One settled word per conversion period
                            result_valid <= 1'b1;
                            result_data <= acc_shifted[DATA_W-1:0];
                            acc_r <= {(DATA_W+4){1'b0}};
                            cnt_r <= 5'h00;
                        end else begin
                            acc_r <= acc_sum;
                            cnt_r <= cnt_r + 5'h01;
                        end
                    end
                    default: begin
                        // Reserved type or no conversion yet: the sample is dropped
                        cnt_r <= 5'h00;
                    end
                endcase
            end
        end
    end

endmodule // pfcfg_top

`default_nettype wire

// file: bench/pfcfg_properties.sv
// Port-level assertions for the filter setup block
`timescale 1ns/1ps
`default_nettype none
module pfcfg_properties #(parameter NUM_SETUPS = 8, parameter DATA_W = 24) (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Conversion side
    input wire logic conv_req,
    input wire logic sinc_valid,
    input wire logic [DATA_W-1:0] sinc_data,
    input wire logic conv_active,
    input wire logic [2:0] filter_type,
    input wire logic type_reserved,
    input wire logic fast_settle,
    input wire logic [10:0] rate_divider_code,
    input wire logic [4:0] avg_depth,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [5:0] idx = paddr[7:2];
    wire filt = idx >= 6'h21 && idx <= 6'h28;
    wire mapped = filt || idx == 6'h30 || idx == 6'h31;
    property p_ready; psel && !penable |=> pready && penable; endproperty
    a_ready: assert property (p_ready) else $error("no access answer");
    property p_decode; pready |-> pslverr == !mapped; endproperty
    a_decode: assert property (p_decode) else $error("bad decode");
    property p_zero; pready && !pwrite && filt |-> prdata[15:11] == 5'h00 && prdata[31:24] == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("unused bits set");
    property p_resv; conv_active |-> type_reserved == (filter_type inside {3'h1, 3'h3, 3'h6, 3'h7}); endproperty
    a_resv: assert property (p_resv) else $error("reserved flag wrong");
    property p_avg; fast_settle |-> avg_depth == 5'h10 || avg_depth == 5'h08; endproperty
    a_avg: assert property (p_avg) else $error("bad depth");
    property p_hold; !conv_req |=> $stable(filter_type) && $stable(rate_divider_code); endproperty
    a_hold: assert property (p_hold) else $error("settings moved");
    property p_pass;
        sinc_valid && conv_active && !fast_settle && !type_reserved && !conv_req && !$past(conv_req)
            |=> result_valid && result_data == $past(sinc_data);
    endproperty
    a_pass: assert property (p_pass) else $error("sample not passed");
    property p_nores; type_reserved && $past(type_reserved) |-> !result_valid; endproperty
    a_nores: assert property (p_nores) else $error("result on reserved");
    c_err: cover property (pready && pslverr);
    c_fast: cover property (result_valid && fast_settle);
    c_resv: cover property (conv_req ##1 type_reserved);
endmodule // pfcfg_properties
bind pfcfg_top pfcfg_properties #(.NUM_SETUPS(NUM_SETUPS), .DATA_W(DATA_W)) u_props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_req(conv_req), .sinc_valid(sinc_valid), .sinc_data(sinc_data),
    .conv_active(conv_active), .filter_type(filter_type), .type_reserved(type_reserved),
    .fast_settle(fast_settle), .rate_divider_code(rate_divider_code), .avg_depth(avg_depth),
    .result_valid(result_valid), .result_data(result_data));
`default_nettype wire

// file: bench/per_setup_filter_config_tb_top.sv
// Self-checking bench for the filter setup block
`timescale 1ns/1ps
`default_nettype none
module per_setup_filter_config_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_req = 0, sinc_valid = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [2:0] conv_setup = 0, filter_type, post_filter_sel, settle_periods;
    logic [23:0] sinc_data = 0, result_data;
    logic [10:0] rate_divider_code;
    logic [4:0] avg_depth;
    logic pready, pslverr, conv_active, type_reserved, fast_settle, sixty_hz_notch_enable, single_cycle;
    logic result_valid, e, fs;
    int n_fail = 0, num_checks = 0, i, k;
    always #25 pclk = ~pclk;
    pfcfg_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_req(conv_req), .conv_setup(conv_setup), .sinc_valid(sinc_valid), .sinc_data(sinc_data),
        .conv_active(conv_active), .filter_type(filter_type), .type_reserved(type_reserved),
        .fast_settle(fast_settle), .sixty_hz_notch_enable(sixty_hz_notch_enable),
        .post_filter_sel(post_filter_sel), .single_cycle(single_cycle), .rate_divider_code(rate_divider_code),
        .avg_depth(avg_depth), .settle_periods(settle_periods), .result_valid(result_valid),
        .result_data(result_data));
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // Bounded wait on pready (0) or result_valid (1), sampled at rising edges
    task wait_hi(input bit on_res);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while ((on_res ? result_valid : pready) !== 1'b1 && k < 20);
        if ((on_res ? result_valid : pready) !== 1'b1) begin
            n_fail++;
            conclude;
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        wait_hi(0);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Settings land at the edge that takes the request
    task conv(input logic [2:0] s);
        @(posedge pclk);
        conv_req <= 1;
        conv_setup <= s;
        @(posedge pclk);
        conv_req <= 0;
        #1;
    endtask
    task smp(input logic [23:0] d);
        @(posedge pclk);
        sinc_valid <= 1;
        sinc_data <= d;
    endtask
    task res;
        @(posedge pclk);
        sinc_valid <= 0;
        wait_hi(1);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 8; i++) begin
            apb(0, 8'h84 + 8'(i * 4), 0);
            chk(r, 32'h00060180);
            chk(e, 0);
        end
        for (i = 0; i < 8; i++) apb(1, 8'h84 + 8'(i * 4), 32'hFFFFFFF0 + i);
        for (i = 0; i < 8; i++) begin
            apb(0, 8'h84 + 8'(i * 4), 0);
            chk(r, 32'h00FF07F0 + i);
        end
        apb(0, 8'hFC, 0);
        chk(e, 1);
        chk(r, 0);
        apb(0, 8'hC0, 0);
        chk(r, 2);
        apb(0, 8'hC4, 0);
        chk(r, 0);
        $display("register test done");
        for (i = 0; i < 8; i++) begin
            fs = (i == 4 || i == 5);
            apb(1, 8'h84 + 8'(i * 4), {8'h00, 3'(i), 5'h16, 5'h1F, 11'h5A5});
            conv(3'(i));
            chk(filter_type, i);
            chk(type_reserved, i == 1 || i == 3 || i > 5);
            chk(fast_settle, fs);
            chk(avg_depth, fs ? 16 : 1);
            if (i < 6 && i != 1 && i != 3) chk(settle_periods, fs ? 1 : (i == 2 ? 3 : 4));
            chk(sixty_hz_notch_enable, 1);
            chk(post_filter_sel, 3);
            chk(single_cycle, 0);
            chk(rate_divider_code, 11'h5A5);
        end
        $display("decode test done");
        apb(1, 8'hC0, 0);
        conv(4);
        chk(avg_depth, 8);
        for (i = 0; i < 8; i++) smp(24'h10 + 24'(i));
        res;
        chk(result_data, 24'h13);
        conv(0);
        smp(24'hABCDEF);
        res;
        chk(result_data, 24'hABCDEF);
        apb(1, 8'hC0, 1);
        conv(5);
        chk(avg_depth, 16);
        conv(1);
        smp(24'h000005);
        @(posedge pclk);
        sinc_valid <= 0;
        #1;
        chk(result_valid, 0);
        apb(0, 8'hC4, 0);
        chk(r, 32'h19);
        $display("datapath test done");
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        #1;
        chk(conv_active, 0);
        apb(0, 8'h90, 0);
        chk(r, 32'h00060180);
        $display("reset test done");
        conclude;
    end
endmodule // per_setup_filter_config_tb_top
`default_nettype wire
